// ===== verilog/somix_pkg.sv
// Constants shared by the serial output port 1 mixer register bank
package somix_pkg;

  // Datapath shape
  localparam int SOMIX_PATHS     = 7;
  localparam int SOMIX_SAMPLE_W  = 24;
  localparam int SOMIX_GAIN_W    = 5;
  localparam int SOMIX_SEL_W     = 7;
  localparam int SOMIX_ADDR_W    = 8;
  localparam int SOMIX_DATA_W    = 8;
  localparam int SOMIX_COEF_W    = 16;
  localparam int SOMIX_COEF_FRAC = 14;
  localparam int SOMIX_SCALED_W  = 27;
  localparam int SOMIX_SUM_W     = 30;
  localparam int SOMIX_LATENCY   = 2;

  // Register offsets
  localparam logic [7:0] SOMIX_ADDR_L_F1L   = 8'h5d;
  localparam logic [7:0] SOMIX_ADDR_L_F1R   = 8'h5e;
  localparam logic [7:0] SOMIX_ADDR_L_F2L   = 8'h5f;
  localparam logic [7:0] SOMIX_ADDR_L_F2R   = 8'h60;
  localparam logic [7:0] SOMIX_ADDR_L_TONE  = 8'h61;
  localparam logic [7:0] SOMIX_ADDR_L_SIL   = 8'h62;
  localparam logic [7:0] SOMIX_ADDR_L_SIR   = 8'h63;
  localparam logic [7:0] SOMIX_ADDR_R_SEL   = 8'h64;
  localparam logic [7:0] SOMIX_GAIN_ADDR [SOMIX_PATHS] = '{
    SOMIX_ADDR_L_F1L, SOMIX_ADDR_L_F1R, SOMIX_ADDR_L_F2L, SOMIX_ADDR_L_F2R,
    SOMIX_ADDR_L_TONE, SOMIX_ADDR_L_SIL, SOMIX_ADDR_L_SIR};

  // Field positions and reset values
  localparam int          SOMIX_GAIN_LSB   = 0;
  localparam int          SOMIX_SEL_LSB    = 0;
  localparam logic [4:0]  SOMIX_GAIN_RESET = 5'h1c;
  localparam logic [6:0]  SOMIX_SEL_RESET  = 7'h04;
  localparam logic [4:0]  SOMIX_GAIN_UNITY = 5'h1c;

  // Linear gain per code, 2.14 unsigned: -42 dB up to +4.5 dB in 1.5 dB steps
  localparam logic [15:0] SOMIX_COEF [32] = '{
    16'h0082, 16'h009b, 16'h00b8, 16'h00da, 16'h0104, 16'h0135, 16'h016f, 16'h01b4,
    16'h0206, 16'h0268, 16'h02dc, 16'h0366, 16'h040a, 16'h04cd, 16'h05b4, 16'h06c7,
    16'h080f, 16'h0993, 16'h0b62, 16'h0d87, 16'h1013, 16'h131b, 16'h16b5, 16'h1afd,
    16'h2013, 16'h261f, 16'h2d4f, 16'h35d9, 16'h4000, 16'h4c10, 16'h5a67, 16'h6b71};

endpackage

// ===== verilog/somix_path_gain.sv
// One mixer path: gain code lookup and registered scaling of a sample
`timescale 1ns/1ps
module somix_path_gain #(
  parameter int SAMPLE_W = somix_pkg::SOMIX_SAMPLE_W
) (
  // Clock and reset
  input  wire logic                                      i_clk,
  input  wire logic                                      i_reset,
  // Gain code and sample
  input  wire logic [somix_pkg::SOMIX_GAIN_W-1:0]        i_code,
  input  wire logic signed [SAMPLE_W-1:0]                i_sample,
  // Scaled sample, one cycle later
  output logic signed [somix_pkg::SOMIX_SCALED_W-1:0]    o_scaled
);
  import somix_pkg::*;

  wire logic [SOMIX_COEF_W-1:0]            coef;
  wire logic signed [SOMIX_COEF_W:0]       coef_signed;
  wire logic signed [SAMPLE_W+SOMIX_COEF_W:0] product;

  // Code to linear factor, a fixed dB-linear table
  assign coef        = SOMIX_COEF[i_code];
  assign coef_signed = $signed({1'b0, coef});
  assign product     = i_sample * coef_signed;

  // Floor the 14 fraction bits; unity code passes the sample unchanged
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_scaled <= '0;
    end else begin
      o_scaled <= product[SOMIX_COEF_FRAC +: SOMIX_SCALED_W];
    end
  end

  // Unity code is exact
  AST_UNITY_PASS: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_code == SOMIX_GAIN_UNITY) |=> (o_scaled == SOMIX_SCALED_W'($past(i_sample))))
    else $error("unity gain code altered the sample");

  // Lowest code gives the -42 dB factor; widen first so the product cannot wrap
  AST_MIN_GAIN: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_code == 5'h00) |=>
      (o_scaled == SOMIX_SCALED_W'(((SAMPLE_W + SOMIX_COEF_W + 1)'($past(i_sample)) *
                                    $signed({1'b0, SOMIX_COEF[0]})) >>> SOMIX_COEF_FRAC)))
    else $error("code zero did not apply the lowest gain");

endmodule

// ===== verilog/somix_mixer_regs.sv
// Serial output port 1 mixer: gain and source-select registers and mixing
//
// Summary of operation
// - Each of the seven sources into the left stream has its own gain register.
// - Each gain is a five-bit read/write field in bits 4 to 0 of its register.
// - Code zero is -42 dB and each code step adds 1.5 dB, linear in dB.
// - Code 0x1c is 0 dB and the top codes give 1.5, 3.0 and 4.5 dB.
// - Every gain field resets to 0x1c, unity gain.
// - A seven-bit read/write select field in bits 6 to 0 picks right-stream inputs.
// - Select bits 0 to 6 map to filter 1 L/R, filter 2 L/R, tone, serial input L/R.
// - A set select bit includes its input, a clear bit excludes it, each independently.
// - The select field resets to 0x4, only filter 2 left.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module somix_mixer_regs #(
  parameter int SAMPLE_W = somix_pkg::SOMIX_SAMPLE_W
) (
  // Clock and reset
  input  wire logic                                  i_clk,
  input  wire logic                                  i_reset,
  // Register port
  input  wire logic [somix_pkg::SOMIX_ADDR_W-1:0]    i_addr,
  input  wire logic [somix_pkg::SOMIX_DATA_W-1:0]    i_wdata,
  input  wire logic                                  i_wr,
  input  wire logic                                  i_rd,
  output logic [somix_pkg::SOMIX_DATA_W-1:0]         o_rdata,
  // Input samples, all qualified by one strobe
  input  wire logic                                  i_valid,
  input  wire logic signed [SAMPLE_W-1:0]            i_filter1_left_input,
  input  wire logic signed [SAMPLE_W-1:0]            i_filter1_right_input,
  input  wire logic signed [SAMPLE_W-1:0]            i_filter2_left_input,
  input  wire logic signed [SAMPLE_W-1:0]            i_filter2_right_input,
  input  wire logic signed [SAMPLE_W-1:0]            i_tone_input,
  input  wire logic signed [SAMPLE_W-1:0]            i_serial_in1_left,
  input  wire logic signed [SAMPLE_W-1:0]            i_serial_in1_right,
  // Mixed output streams
  output logic                                       o_valid,
  output logic signed [SAMPLE_W-1:0]                 o_serial_out1_left_stream,
  output logic signed [SAMPLE_W-1:0]                 o_serial_out1_right_stream
);
  import somix_pkg::*;

  localparam logic signed [SOMIX_SUM_W-1:0] SAT_MAX = SOMIX_SUM_W'((2**(SAMPLE_W-1)) - 1);
  localparam logic signed [SOMIX_SUM_W-1:0] SAT_MIN = -SOMIX_SUM_W'(2**(SAMPLE_W-1));

  // Register state
  logic [SOMIX_GAIN_W-1:0]                 left_stream_level [SOMIX_PATHS];
  logic [SOMIX_SEL_W-1:0]                  right_stream_source_bits;
  // Pipeline state
  logic                                    valid_s1;
  logic signed [SOMIX_SUM_W-1:0]           right_sum_s1;

  // Decode wires
  wire logic [SOMIX_PATHS-1:0]             gain_hit;
  wire logic                               sel_hit;
  wire logic [SOMIX_GAIN_W-1:0]            gain_rd_terms [SOMIX_PATHS];
  logic [SOMIX_GAIN_W-1:0]                 gain_rd_value;
  wire logic [SOMIX_DATA_W-1:0]            next_rdata;

  // Datapath wires
  wire logic signed [SAMPLE_W-1:0]         samples [SOMIX_PATHS];
  wire logic signed [SOMIX_SCALED_W-1:0]   scaled [SOMIX_PATHS];
  logic signed [SOMIX_SUM_W-1:0]           next_left_sum;
  logic signed [SOMIX_SUM_W-1:0]           next_right_sum;

  // Saturate a wide sum into the sample width instead of wrapping
  function automatic logic signed [SAMPLE_W-1:0] somix_sat(
    input logic signed [SOMIX_SUM_W-1:0] value
  );
    logic signed [SAMPLE_W-1:0] result;
    if (value > SAT_MAX) begin
      result = SAT_MAX[SAMPLE_W-1:0];
    end else if (value < SAT_MIN) begin
      result = SAT_MIN[SAMPLE_W-1:0];
    end else begin
      result = value[SAMPLE_W-1:0];
    end
    return result;
  endfunction

  // Source order matches the select bit order
  assign samples[0] = i_filter1_left_input;
  assign samples[1] = i_filter1_right_input;
  assign samples[2] = i_filter2_left_input;
  assign samples[3] = i_filter2_right_input;
  assign samples[4] = i_tone_input;
  assign samples[5] = i_serial_in1_left;
  assign samples[6] = i_serial_in1_right;

  // Address decode
  assign sel_hit = (i_addr == SOMIX_ADDR_R_SEL);

  // Per-path gain register, decode and scaler
  genvar k;
  generate
    for (k = 0; k < SOMIX_PATHS; k++) begin : g_path
      assign gain_hit[k]      = (i_addr == SOMIX_GAIN_ADDR[k]);
      assign gain_rd_terms[k] = gain_hit[k] ? left_stream_level[k] : '0;

      // Gain field write; upper bits of the write are dropped
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          left_stream_level[k] <= SOMIX_GAIN_RESET;
        end else if (i_wr && gain_hit[k]) begin
          left_stream_level[k] <= i_wdata[SOMIX_GAIN_LSB +: SOMIX_GAIN_W];
        end
      end

      somix_path_gain #(
        .SAMPLE_W (SAMPLE_W)
      ) u_gain (
        .i_clk    (i_clk),
        .i_reset  (i_reset),
        .i_code   (left_stream_level[k]),
        .i_sample (samples[k]),
        .o_scaled (scaled[k])
      );

      AST_GAIN_WRITE: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_wr && gain_hit[k]) |=>
          (left_stream_level[k] == $past(i_wdata[SOMIX_GAIN_LSB +: SOMIX_GAIN_W])))
        else $error("gain field did not take the written code");

      // A gain field only moves on a write to its own address
      AST_GAIN_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
        !(i_wr && gain_hit[k]) |=> $stable(left_stream_level[k]))
        else $error("gain field changed without a write to it");
    end
  endgenerate

  // Select field write
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      right_stream_source_bits <= SOMIX_SEL_RESET;
    end else if (i_wr && sel_hit) begin
      right_stream_source_bits <= i_wdata[SOMIX_SEL_LSB +: SOMIX_SEL_W];
    end
  end

  // Read mux; addresses decode to one hit at most, so OR is enough
  always_comb begin
    gain_rd_value = '0;
    for (int j = 0; j < SOMIX_PATHS; j++) begin
      gain_rd_value = gain_rd_value | gain_rd_terms[j];
    end
  end

  // Reserved bits read as zero, unmapped addresses read as zero
  assign next_rdata = sel_hit ? {1'b0, right_stream_source_bits} :
                      {3'h0, gain_rd_value};

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_rd ? next_rdata : '0;
    end
  end

  // Left takes every scaled path; right adds only selected raw inputs
  always_comb begin
    next_left_sum  = '0;
    next_right_sum = '0;
    for (int j = 0; j < SOMIX_PATHS; j++) begin
      next_left_sum = next_left_sum + SOMIX_SUM_W'(scaled[j]);
      if (right_stream_source_bits[j]) begin
        next_right_sum = next_right_sum + SOMIX_SUM_W'(samples[j]);
      end
    end
  end

  // Stage one: scalers run, right sum is aligned with them
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      valid_s1     <= 1'b0;
      right_sum_s1 <= '0;
    end else begin
      valid_s1     <= i_valid;
      right_sum_s1 <= next_right_sum;
    end
  end

  // Stage two: saturate and hold the outputs until the next sample
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_valid                    <= 1'b0;
      o_serial_out1_left_stream  <= '0;
      o_serial_out1_right_stream <= '0;
    end else begin
      o_valid <= valid_s1;
      if (valid_s1) begin
        o_serial_out1_left_stream  <= somix_sat(next_left_sum);
        o_serial_out1_right_stream <= somix_sat(right_sum_s1);
      end
    end
  end

  // Reset values seen at the first active cycle
  AST_RESET_VALUES: assert property (@(posedge i_clk) disable iff (i_reset)
    $past(i_reset) |-> (left_stream_level[0] == SOMIX_GAIN_RESET &&
                        left_stream_level[6] == SOMIX_GAIN_RESET &&
                        right_stream_source_bits == SOMIX_SEL_RESET))
    else $error("registers did not come out of reset at their defaults");

  AST_SEL_WRITE: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_wr && sel_hit) |=> (right_stream_source_bits == $past(i_wdata[6:0])))
    else $error("select field did not take the written bits");

  AST_READ_SEL: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_rd && sel_hit) |=> (o_rdata == {1'b0, right_stream_source_bits}))
    else $error("select read back wrong or reserved bit set");

  AST_READ_GAIN: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_rd && gain_hit[4] && !i_wr) |=> (o_rdata == {3'h0, left_stream_level[4]}))
    else $error("tone gain read back wrong");

  AST_READ_IDLE: assert property (@(posedge i_clk) disable iff (i_reset)
    (!i_rd || (!sel_hit && gain_hit == '0)) |=> (o_rdata == 8'h00))
    else $error("read data not zero outside a mapped read");

  AST_LATENCY: assert property (@(posedge i_clk) disable iff (i_reset)
    i_valid |-> ##2 o_valid)
    else $error("output sample not two cycles after input");

  AST_RIGHT_NONE: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_valid && right_stream_source_bits == 7'h00) |-> ##2 (o_serial_out1_right_stream == '0))
    else $error("right stream not silent with no source selected");

  AST_RIGHT_DEFAULT: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_valid && right_stream_source_bits == SOMIX_SEL_RESET) |->
      ##2 (o_serial_out1_right_stream == $past(i_filter2_left_input, 2)))
    else $error("default select did not pass filter 2 left alone");

  AST_LEFT_UNITY: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_valid && i_filter1_right_input == '0 && i_filter2_left_input == '0 &&
     i_filter2_right_input == '0 && i_tone_input == '0 && i_serial_in1_left == '0 &&
     i_serial_in1_right == '0 && left_stream_level[0] == SOMIX_GAIN_UNITY) |->
      ##2 (o_serial_out1_left_stream == $past(i_filter1_left_input, 2)))
    else $error("single unity path did not pass through the left stream");

  // Unmapped writes and gain writes leave the select field alone
  AST_SEL_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
    !(i_wr && sel_hit) |=> $stable(right_stream_source_bits))
    else $error("select field changed without a write to it");

  // One output strobe per input strobe, never an extra one
  AST_VALID_PULSE: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_valid |-> ##2 !o_valid)
    else $error("output strobe without an input strobe");

  // Streams hold between output strobes so a slow reader sees a steady value
  AST_STREAM_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
    !valid_s1 |=> ($stable(o_serial_out1_left_stream) &&
                   $stable(o_serial_out1_right_stream)))
    else $error("stream output moved without a sample");

  // Tone bit alone routes only the tone input to the right stream
  AST_RIGHT_TONE: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_valid && right_stream_source_bits == 7'h10) |->
      ##2 (o_serial_out1_right_stream == $past(i_tone_input, 2)))
    else $error("tone select bit did not route the tone input alone");

endmodule

// ===== verification/somix_tb.sv
// Self-checking bench for the port 1 mixer register bank
`timescale 1ns/1ps
module tb;
  import somix_pkg::*;
  localparam int TIMEOUT_CYCLES = 20000;
  // Clock, reset and register port
  logic               clk;
  logic               reset;
  logic [7:0]         addr;
  logic [7:0]         wdata;
  logic               wr;
  logic               rd;
  logic [7:0]         rdata;
  // Samples and streams
  logic               valid;
  logic signed [23:0] smp [SOMIX_PATHS];
  logic signed [23:0] nxt [SOMIX_PATHS];
  logic               out_valid;
  logic signed [23:0] left_out;
  logic signed [23:0] right_out;
  int                 mismatches;
  int                 checked;
  int                 cycles;

  somix_mixer_regs #(.SAMPLE_W(24)) u_dut (
    .i_clk(clk), .i_reset(reset), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_valid(valid), .i_filter1_left_input(smp[0]),
    .i_filter1_right_input(smp[1]), .i_filter2_left_input(smp[2]),
    .i_filter2_right_input(smp[3]), .i_tone_input(smp[4]), .i_serial_in1_left(smp[5]),
    .i_serial_in1_right(smp[6]), .o_valid(out_valid),
    .o_serial_out1_left_stream(left_out), .o_serial_out1_right_stream(right_out));

  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard, sized well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYCLES) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk24(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Gain tables are quantised, so allow a small relative error
  task automatic chk_near(input string what, input real exp, input logic signed [23:0] got);
    real d;
    d = $itor(got) - exp;
    if (d < 0.0)
      d = -d;
    checked++;
    if (^got === 1'bx || d > exp * 0.006 + 2.0) begin
      mismatches++;
      $display("[ERR] %s expected %f seen %0d", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands for one cycle only, then returns to zero
  task automatic reg_read_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk8("o_rdata", exp, rdata);
    @(posedge clk);
    #1 chk8("o_rdata idle", 8'h00, rdata);
  endtask

  // One sample strobe; streams land on the second edge after the strobe is driven
  task automatic fire();
    @(posedge clk);
    valid <= 1'b1;
    for (int k = 0; k < SOMIX_PATHS; k++)
      smp[k] <= nxt[k];
    @(posedge clk);
    valid <= 1'b0;
    #1 chk8("o_valid early", 8'h00, {7'h0, out_valid});
    @(posedge clk);
    #1 chk8("o_valid", 8'h01, {7'h0, out_valid});
  endtask

  task automatic t_reset_values();
    for (int p = 0; p < SOMIX_PATHS; p++)
      reg_read_chk(SOMIX_GAIN_ADDR[p], 8'h1c);
    reg_read_chk(SOMIX_ADDR_R_SEL, 8'h04);
    reg_read_chk(8'h65, 8'h00);
    reg_read_chk(8'h5c, 8'h00);
  endtask

  task automatic t_read_write();
    for (int p = 0; p < SOMIX_PATHS; p++) begin
      reg_write(SOMIX_GAIN_ADDR[p], 8'he0 | 8'(p));
      reg_read_chk(SOMIX_GAIN_ADDR[p], 8'(p));
      reg_write(SOMIX_GAIN_ADDR[p], 8'hff);
      reg_read_chk(SOMIX_GAIN_ADDR[p], 8'h1f);
    end
    reg_write(SOMIX_ADDR_R_SEL, 8'hff);
    reg_read_chk(SOMIX_ADDR_R_SEL, 8'h7f);
    reg_write(SOMIX_ADDR_R_SEL, 8'h80);
    reg_read_chk(SOMIX_ADDR_R_SEL, 8'h00);
    reg_write(8'h65, 8'hff);
    reg_read_chk(8'h65, 8'h00);
    // Reset in mid-run must restore the fields; the serial input right gain and the select are read back
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    reg_read_chk(SOMIX_ADDR_L_SIR, 8'h1c);
    reg_read_chk(SOMIX_ADDR_R_SEL, 8'h04);
  endtask

  task automatic t_select();
    for (int k = 0; k < SOMIX_PATHS; k++)
      nxt[k] = 24'((k + 1) * 'h1000);
    fire();
    chk24("right default", 24'h003000, right_out);
    chk24("left unity sum", 24'h01c000, left_out);
    for (int b = 0; b < SOMIX_PATHS; b++) begin
      reg_write(SOMIX_ADDR_R_SEL, 8'(1 << b));
      fire();
      chk24("right single", 24'((b + 1) * 'h1000), right_out);
    end
    reg_write(SOMIX_ADDR_R_SEL, 8'h55);
    fire();
    chk24("right mix", 24'h010000, right_out);
    reg_write(SOMIX_ADDR_R_SEL, 8'h00);
    fire();
    chk24("right none", 24'h000000, right_out);
  endtask

  task automatic t_gain();
    int codes [7] = '{0, 1, 2, 27, 28, 29, 30};
    for (int p = 0; p < SOMIX_PATHS; p++) begin
      for (int k = 0; k < SOMIX_PATHS; k++)
        nxt[k] = (k == p) ? 24'h100000 : 24'h000000;
      reg_write(SOMIX_GAIN_ADDR[p], 8'h1f);
      fire();
      chk_near("left path max", 1048576.0 * 10.0 ** (4.5 / 20.0), left_out);
      reg_write(SOMIX_GAIN_ADDR[p], 8'h1c);
      fire();
      chk24("left path unity", 24'h100000, left_out);
    end
    for (int i = 0; i < 7; i++) begin
      reg_write(SOMIX_ADDR_L_SIR, 8'(codes[i]));
      fire();
      chk_near("left code", 1048576.0 * 10.0 ** ((codes[i] * 1.5 - 42.0) / 20.0),
               left_out);
    end
    reg_write(SOMIX_ADDR_L_SIR, 8'h1c);
  endtask

  task automatic t_saturate();
    reg_write(SOMIX_ADDR_R_SEL, 8'h7f);
    for (int k = 0; k < SOMIX_PATHS; k++)
      nxt[k] = 24'h7fffff;
    fire();
    chk24("left high", 24'h7fffff, left_out);
    chk24("right high", 24'h7fffff, right_out);
    for (int k = 0; k < SOMIX_PATHS; k++)
      nxt[k] = 24'h800000;
    fire();
    chk24("left low", 24'h800000, left_out);
    chk24("right low", 24'h800000, right_out);
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    valid = 1'b0;
    mismatches = 0;
    checked = 0;
    cycles = 0;
    for (int k = 0; k < SOMIX_PATHS; k++) begin
      smp[k] = 24'h000000;
      nxt[k] = 24'h000000;
    end
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_reset_values();
    t_read_write();
    t_select();
    t_gain();
    t_saturate();
    stop_test();
  end
endmodule
